// file: ebw_pkg.sv
// Shared constants, types and helpers for the external bus wait controller.
// Assumes a 25 MHz system clock; the files that use these names refer to them by scope.
package ebw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on the plain register port
  localparam logic [1:0] OFS_MODE = 2'h0; // Memory extension mode
  localparam logic [1:0] OFS_WAIT_LOW = 2'h1; // Waits for the four low spaces
  localparam logic [1:0] OFS_WAIT_HIGH = 2'h2; // Waits for the four high spaces
  localparam logic [1:0] OFS_STATUS = 2'h3; // Read-only block state

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and fixed fields
  localparam logic [7:0] MODE_RESET = 8'h20; // External cycle for ROM, address wait on
  localparam logic [7:0] WAIT_LOW_RESET = 8'hAA; // Two waits in every low space
  localparam logic [15:0] WAIT_HIGH_RESET = 16'hAAAA; // Two waits in every high space
  localparam logic [7:0] WAIT_HIGH_FIXED = 8'hAA; // Upper byte is fixed

  ////////////////////////////////////////////////////////////////////////////
  // Mode register fields
  localparam int MODE_SIZE_LSB = 0; // Extension size, three bits
  localparam int MODE_AW_BIT = 5; // address_wait_enable
  localparam int MODE_FETCH_BIT = 6; // rom_fetch_cycle_select, 1 = high-speed fetch

  // Extension size codes
  localparam logic [2:0] SIZE_SINGLE = 3'h0; // No external bus
  localparam logic [2:0] SIZE_256B = 3'h1;
  localparam logic [2:0] SIZE_4K = 3'h2;
  localparam logic [2:0] SIZE_16K = 3'h3;
  localparam logic [2:0] SIZE_64K = 3'h4;
  localparam logic [2:0] SIZE_256K = 3'h5;

  // Two-bit wait field codes
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_ONE = 2'h1;
  localparam logic [1:0] WAIT_TWO = 2'h2;
  localparam logic [1:0] WAIT_EXT = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Internal memory map and the external SFR window
  localparam logic [19:0] ROM_LOW_END = 20'h0EE00; // First address past low ROM
  localparam logic [19:0] ROM_HIGH_BASE = 20'h10000; // Upper ROM block start
  localparam logic [19:0] ROM_HIGH_END = 20'h20000; // First address past upper ROM
  localparam logic [19:0] SFR_BASE = 20'h0FF00; // Internal SFR start, RAM below
  localparam logic [19:0] XSFR_BASE = 20'h0FFD0; // External SFR window start
  localparam logic [19:0] XSFR_END = 20'h0FFDF; // External SFR window end

  // Time for one access wait, and its cycle count at 25 MHz
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAIT_STEP_NS = 40;
  localparam int WAIT_STEP_CYC = (WAIT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [19:0] addr; // Program address
    logic write; // 1 = write
    logic [7:0] wdata; // Write byte
  } ebw_req_s;

  typedef enum logic [3:0] {
    RGN_EXT = 4'h1, // External memory
    RGN_ROM = 4'h2, // Internal ROM
    RGN_RAM = 4'h4, // Internal RAM
    RGN_SFR = 4'h8 // Internal SFR
  } ebw_region_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, // Waiting for a request
    ST_ADDR = 5'h02, // Address out, latch strobe high
    ST_AWAIT = 5'h04, // Address wait, latch strobe held high
    ST_DATA = 5'h08, // Read or write strobe low
    ST_END = 5'h10 // Strobes released, answer given
  } ebw_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Mask of the address bits that reach the pins for a size code
  function automatic logic [19:0] ext_mask(input logic [2:0] size);
    logic [19:0] m;
    m = 20'hFFFFF;
    unique case (size)
      SIZE_SINGLE: m = 20'h00000;
      SIZE_256B: m = 20'h000FF;
      SIZE_4K: m = 20'h00FFF;
      SIZE_16K: m = 20'h03FFF;
      SIZE_64K: m = 20'h0FFFF;
      SIZE_256K: m = 20'h3FFFF;
      default: m = 20'hFFFFF; // Both remaining codes are the 1-Mbyte mode
    endcase
    return m;
  endfunction : ext_mask

endpackage : ebw_pkg

// file: ebw_sync.sv
// Two-stage synchroniser for pin inputs of any width.
// Assumes the pins are asynchronous to CLK_I; only the second stage is read.
`timescale 1ns/1ps
`default_nettype none
module ebw_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1; // First stage, read only by the second

  // Two flip-flops in series
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      stage1 <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule : ebw_sync
`default_nettype wire

// file: ebw_space_decode.sv
// Address classification and wait field selection for one request.
// Assumes registered mode and wait settings; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module ebw_space_decode (
  input wire logic [19:0] addr_i,
  input wire logic [7:0] mode_i,
  input wire logic [7:0] wait_low_i,
  input wire logic [7:0] wait_high_i,
  output ebw_pkg::ebw_region_e region_o,
  output logic [1:0] wait_sel_o,
  output logic ext_wait_used_o
);

  logic [2:0] size; // Extension size code
  logic in_rom; // Hit in either ROM block
  logic in_xsfr; // Hit in the external SFR window

  // Region of the address
  always_comb
  begin
    size = mode_i[ebw_pkg::MODE_SIZE_LSB +: 3];
    in_rom = (addr_i < ebw_pkg::ROM_LOW_END) ||
             ((addr_i >= ebw_pkg::ROM_HIGH_BASE) && (addr_i < ebw_pkg::ROM_HIGH_END));
    in_xsfr = (addr_i >= ebw_pkg::XSFR_BASE) && (addr_i <= ebw_pkg::XSFR_END);
    if (in_rom)
      region_o = ebw_pkg::RGN_ROM;
    else if ((addr_i >= ebw_pkg::ROM_LOW_END) && (addr_i < ebw_pkg::SFR_BASE))
      region_o = ebw_pkg::RGN_RAM;
    else if ((addr_i >= ebw_pkg::SFR_BASE) && (addr_i < ebw_pkg::ROM_HIGH_BASE))
      // Window goes outside only when the bus is in use
      region_o = (in_xsfr && (size != ebw_pkg::SIZE_SINGLE)) ? ebw_pkg::RGN_EXT
                                                             : ebw_pkg::RGN_SFR;
    else
      region_o = ebw_pkg::RGN_EXT;
  end

  // Eight spaces: four 16-Kbyte below 10000H, four above it
  always_comb
  begin
    if (addr_i[19:16] == 4'h0)
      wait_sel_o = wait_low_i[{addr_i[15:14], 1'b0} +: 2];
    else
      wait_sel_o = wait_high_i[{addr_i[19:18], 1'b0} +: 2];
  end

  // Wait pin is needed when any space selects external control
  always_comb
  begin
    ext_wait_used_o = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if ((wait_low_i[2*i +: 2] == ebw_pkg::WAIT_EXT) ||
          (wait_high_i[2*i +: 2] == ebw_pkg::WAIT_EXT))
        ext_wait_used_o = 1'b1;
    end
  end

endmodule : ebw_space_decode
`default_nettype wire

// file: ebw_bus_ctrl.sv
// Top of the external local bus controller with wait insertion.
// Assumes a single-cycle register port and a CPU that waits for the answer.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ebw_bus_ctrl (
  input wire logic CLK_I,
  input wire logic RESET_I,
  // CPU request side
  input wire logic REQ_VALID_I,
  input wire ebw_pkg::ebw_req_s REQ_I,
  output logic BUSY_O,
  output logic ACK_O,
  output logic [7:0] RDATA_O,
  output logic INTERNAL_O,
  // Register port
  input wire logic [1:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  // Local bus pins
  output logic ADDRESS_LATCH_STROBE_O,
  output logic RD_N_O,
  output logic WR_N_O,
  output logic [7:0] MUXED_ADDR_DATA_O,
  output logic MUXED_ADDR_DATA_OE_O,
  input wire logic [7:0] MUXED_ADDR_DATA_I,
  output logic [11:0] UPPER_ADDR_O,
  output logic [11:0] UPPER_ADDR_OE_O,
  input wire logic WAIT_N_I,
  // Pin function selects
  output logic STROBE_PINS_EN_O,
  output logic WAIT_PIN_EN_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] mode; // memory_extension_mode
  logic [7:0] wait_low; // wait_control_low_spaces
  logic [7:0] wait_high; // Low byte of wait_control_high_spaces
  ebw_pkg::ebw_state_e state; // Bus cycle state
  ebw_pkg::ebw_state_e next_state;
  ebw_pkg::ebw_req_s req; // Request being served
  logic pins_on; // Cycle of the held request reaches the pins
  logic next_pins_on;
  logic [1:0] wait_cnt; // Access waits still to insert
  logic ext_wait; // Held request uses the wait pin
  logic [1:0] dec_wait_sel; // Wait field of the incoming address
  ebw_pkg::ebw_region_e dec_region; // Region of the incoming address
  logic dec_ext_used; // Some space selects the wait pin
  logic [7:0] ad_sync; // Synchronised address/data pins
  logic wait_n_sync; // Synchronised wait pin
  logic [2:0] size; // Extension size code
  logic bus_on; // Extension mode active
  logic fast; // Incoming request finishes without a bus cycle
  logic [19:0] size_mask; // Address bits that reach the pins
  logic [19:0] out_addr; // Masked incoming address for the pins

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  ebw_space_decode u_decode (
    .addr_i(REQ_I.addr),
    .mode_i(mode),
    .wait_low_i(wait_low),
    .wait_high_i(wait_high),
    .region_o(dec_region),
    .wait_sel_o(dec_wait_sel),
    .ext_wait_used_o(dec_ext_used)
  );

  ebw_sync #(
    .WIDTH(9)
  ) u_sync (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .async_i({WAIT_N_I, MUXED_ADDR_DATA_I}),
    .sync_o({wait_n_sync, ad_sync})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of the incoming request
  always_comb
  begin
    size = mode[ebw_pkg::MODE_SIZE_LSB +: 3];
    bus_on = (size != ebw_pkg::SIZE_SINGLE);
    // RAM, SFR and fast-fetch ROM skip the cycle entirely
    fast = (dec_region == ebw_pkg::RGN_RAM) || (dec_region == ebw_pkg::RGN_SFR) ||
           ((dec_region == ebw_pkg::RGN_ROM) && mode[ebw_pkg::MODE_FETCH_BIT]) ||
           ((dec_region == ebw_pkg::RGN_EXT) && !bus_on);
    // Only external hits toggle pins; internal ROM runs the timing silently
    next_pins_on = (dec_region == ebw_pkg::RGN_EXT) && bus_on;
    size_mask = ebw_pkg::ext_mask(size);
    out_addr = REQ_I.addr & size_mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the bus cycle
  always_comb
  begin
    next_state = state;
    unique case (state)
      ebw_pkg::ST_IDLE:
      begin
        if (REQ_VALID_I && !fast)
          next_state = ebw_pkg::ST_ADDR;
      end
      ebw_pkg::ST_ADDR:
      begin
        // Address wait also covers ROM on the external cycle
        if (mode[ebw_pkg::MODE_AW_BIT])
          next_state = ebw_pkg::ST_AWAIT;
        else
          next_state = ebw_pkg::ST_DATA;
      end
      ebw_pkg::ST_AWAIT:
        next_state = ebw_pkg::ST_DATA;
      ebw_pkg::ST_DATA:
      begin
        // Programmed count first, then the wait pin if selected
        if ((wait_cnt == 2'h0) && !(ext_wait && !wait_n_sync))
          next_state = ebw_pkg::ST_END;
      end
      ebw_pkg::ST_END:
        next_state = ebw_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      state <= ebw_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture of the request and its wait selection
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      req <= '0;
      pins_on <= 1'b0;
      ext_wait <= 1'b0;
    end
    else if ((state == ebw_pkg::ST_IDLE) && REQ_VALID_I && !fast)
    begin
      req <= REQ_I;
      pins_on <= next_pins_on;
      // External control applies even to ROM, which may hang it
      ext_wait <= (dec_wait_sel == ebw_pkg::WAIT_EXT);
    end
  end

  // Access wait counter, loaded when a request arrives in idle
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      wait_cnt <= 2'h0;
    else if ((state == ebw_pkg::ST_IDLE) && REQ_VALID_I)
      // External control counts no fixed waits
      wait_cnt <= (dec_wait_sel == ebw_pkg::WAIT_EXT) ? 2'h0 : dec_wait_sel;
    else if ((state == ebw_pkg::ST_DATA) && (wait_cnt != 2'h0))
      wait_cnt <= wait_cnt - 2'(ebw_pkg::WAIT_STEP_CYC);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus pins, all registered from the next state
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      ADDRESS_LATCH_STROBE_O <= 1'b0;
      RD_N_O <= 1'b1;
      WR_N_O <= 1'b1;
      MUXED_ADDR_DATA_OE_O <= 1'b0;
    end
    else
    begin
      unique case (next_state)
        ebw_pkg::ST_ADDR, ebw_pkg::ST_AWAIT:
        begin
          // Latch strobe high, held one extra cycle in the wait
          ADDRESS_LATCH_STROBE_O <= (state == ebw_pkg::ST_IDLE) ? next_pins_on : pins_on;
          RD_N_O <= 1'b1;
          WR_N_O <= 1'b1;
          MUXED_ADDR_DATA_OE_O <= (state == ebw_pkg::ST_IDLE) ? next_pins_on : pins_on;
        end
        ebw_pkg::ST_DATA:
        begin
          // Latch falls, strobe goes low
          ADDRESS_LATCH_STROBE_O <= 1'b0;
          RD_N_O <= !(pins_on && !req.write);
          WR_N_O <= !(pins_on && req.write);
          MUXED_ADDR_DATA_OE_O <= pins_on && req.write;
        end
        default:
        begin
          // Idle and end: strobes inactive, bus released
          ADDRESS_LATCH_STROBE_O <= 1'b0;
          RD_N_O <= 1'b1;
          WR_N_O <= 1'b1;
          MUXED_ADDR_DATA_OE_O <= 1'b0;
        end
      endcase
    end
  end

  // Address and data values; address held between external cycles
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      MUXED_ADDR_DATA_O <= 8'h00;
      UPPER_ADDR_O <= 12'h000;
    end
    else if ((state == ebw_pkg::ST_IDLE) && REQ_VALID_I && !fast && next_pins_on)
    begin
      // Address goes out with the rising latch strobe
      MUXED_ADDR_DATA_O <= out_addr[7:0];
      UPPER_ADDR_O <= out_addr[19:8];
    end
    else if (pins_on && (next_state == ebw_pkg::ST_DATA) && req.write)
      MUXED_ADDR_DATA_O <= req.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin function selects
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      STROBE_PINS_EN_O <= 1'b0;
      UPPER_ADDR_OE_O <= 12'h000;
      WAIT_PIN_EN_O <= 1'b0;
    end
    else
    begin
      STROBE_PINS_EN_O <= bus_on;
      UPPER_ADDR_OE_O <= size_mask[19:8];
      WAIT_PIN_EN_O <= bus_on && dec_ext_used;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer to the CPU
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      ACK_O <= 1'b0;
      RDATA_O <= 8'h00;
      INTERNAL_O <= 1'b0;
      BUSY_O <= 1'b0;
    end
    else
    begin
      BUSY_O <= (next_state != ebw_pkg::ST_IDLE);
      if ((state == ebw_pkg::ST_IDLE) && REQ_VALID_I && fast)
      begin
        // Internal hit served elsewhere; no pin activity
        ACK_O <= 1'b1;
        INTERNAL_O <= 1'b1;
      end
      else if ((state == ebw_pkg::ST_DATA) && (next_state == ebw_pkg::ST_END))
      begin
        ACK_O <= 1'b1;
        INTERNAL_O <= !pins_on;
        if (!req.write)
          RDATA_O <= pins_on ? ad_sync : 8'hFF;
      end
      else
      begin
        ACK_O <= 1'b0;
        INTERNAL_O <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      mode <= ebw_pkg::MODE_RESET;
      wait_low <= ebw_pkg::WAIT_LOW_RESET;
      wait_high <= ebw_pkg::WAIT_HIGH_RESET[7:0];
    end
    else if (REG_WR_I)
    begin
      unique case (REG_ADDR_I)
        ebw_pkg::OFS_MODE: mode <= REG_WDATA_I[7:0];
        ebw_pkg::OFS_WAIT_LOW: wait_low <= REG_WDATA_I[7:0];
        // Upper byte is fixed, so written bits above are dropped
        ebw_pkg::OFS_WAIT_HIGH: wait_high <= REG_WDATA_I[7:0];
        default: mode <= mode; // Status is read-only
      endcase
    end
  end

  // Register reads, answered in the following cycle
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      REG_RDATA_O <= 16'h0000;
    else if (REG_RD_I)
    begin
      unique case (REG_ADDR_I)
        ebw_pkg::OFS_MODE: REG_RDATA_O <= {8'h00, mode};
        ebw_pkg::OFS_WAIT_LOW: REG_RDATA_O <= {8'h00, wait_low};
        ebw_pkg::OFS_WAIT_HIGH: REG_RDATA_O <= {ebw_pkg::WAIT_HIGH_FIXED, wait_high};
        default: REG_RDATA_O <= {8'h00, 3'h0, state}; // Cycle state, one-hot
      endcase
    end
    else
      REG_RDATA_O <= 16'h0000;
  end

endmodule : ebw_bus_ctrl
`default_nettype wire

// file: ebw_bus_ctrl_assertions.sv
// Pin and handshake checker for the external bus wait controller.
// Assumes it is bound into every ebw_bus_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ebw_bus_ctrl_assertions (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic ACK_O,
  input wire logic BUSY_O,
  input wire logic INTERNAL_O,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic ADDRESS_LATCH_STROBE_O,
  input wire logic RD_N_O,
  input wire logic WR_N_O,
  input wire logic MUXED_ADDR_DATA_OE_O,
  input wire logic [11:0] UPPER_ADDR_O,
  input wire logic STROBE_PINS_EN_O,
  input wire logic WAIT_PIN_EN_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  wire strobe_low = !RD_N_O || !WR_N_O; // Either access strobe active
  ////////////////////////////////////////////////////////////////////////////
  // Latch strobe held one cycle
  sequence s_latch_short;
    ADDRESS_LATCH_STROBE_O ##1 !ADDRESS_LATCH_STROBE_O;
  endsequence
  // Latch strobe stretched by the address wait
  sequence s_latch_long;
    ADDRESS_LATCH_STROBE_O ##1 s_latch_short;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_latch_width: assert property (
    $rose(ADDRESS_LATCH_STROBE_O) |-> s_latch_short or s_latch_long)
    else $error("latch strobe width wrong");
  a_strobe_follows: assert property (
    $fell(ADDRESS_LATCH_STROBE_O) |-> strobe_low)
    else $error("no access strobe after latch strobe");
  a_latch_before_strobe: assert property (
    $rose(strobe_low) |-> $fell(ADDRESS_LATCH_STROBE_O))
    else $error("access strobe without latch strobe");
  a_strobes_exclusive: assert property (!(!RD_N_O && !WR_N_O))
    else $error("read and write strobes together");
  a_read_released: assert property (!RD_N_O |-> !MUXED_ADDR_DATA_OE_O)
    else $error("data lines driven during read");
  a_write_driven: assert property (!WR_N_O |-> MUXED_ADDR_DATA_OE_O)
    else $error("data lines not driven during write");
  a_strobe_end_ack: assert property (
    $rose(RD_N_O) || $rose(WR_N_O) |-> ACK_O)
    else $error("strobe end without answer");
  a_internal_quiet: assert property (
    INTERNAL_O |-> !strobe_low && !ADDRESS_LATCH_STROBE_O && $stable(UPPER_ADDR_O))
    else $error("pins moved on internal access");
  a_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("answer longer than one cycle");
  a_pins_off_idle: assert property (
    !STROBE_PINS_EN_O |-> !strobe_low && !ADDRESS_LATCH_STROBE_O)
    else $error("strobes while bus pins off");
  a_wait_pin_bus: assert property (WAIT_PIN_EN_O |-> STROBE_PINS_EN_O)
    else $error("wait pin on without bus");
  a_reg_read_only: assert property (REG_RDATA_O != 16'h0000 |-> $past(REG_RD_I))
    else $error("register data without read");
  a_busy_cycle: assert property ($rose(ADDRESS_LATCH_STROBE_O) |-> BUSY_O [*2])
    else $error("not busy during bus cycle");
endmodule : ebw_bus_ctrl_assertions
bind ebw_bus_ctrl ebw_bus_ctrl_assertions u_ebw_bus_ctrl_assertions (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .ACK_O(ACK_O), .BUSY_O(BUSY_O),
  .INTERNAL_O(INTERNAL_O), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .ADDRESS_LATCH_STROBE_O(ADDRESS_LATCH_STROBE_O), .RD_N_O(RD_N_O), .WR_N_O(WR_N_O),
  .MUXED_ADDR_DATA_OE_O(MUXED_ADDR_DATA_OE_O), .UPPER_ADDR_O(UPPER_ADDR_O),
  .STROBE_PINS_EN_O(STROBE_PINS_EN_O), .WAIT_PIN_EN_O(WAIT_PIN_EN_O));
`default_nettype wire

// file: ebw_ext_mem.sv
// External byte memory on the local bus, with a wait output.
// Assumes registered controller pins on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ebw_ext_mem (
  input wire logic clk_i,
  input wire logic als_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] ad_i,
  input wire logic [11:0] upper_i,
  input wire logic [11:0] upper_oe_i,
  input wire logic [3:0] hold_i,
  output logic [7:0] ad_o,
  output logic wait_n_o,
  output logic [19:0] lat_o,
  output logic [7:0] wdat_o
);
  logic [7:0] mem [256]; // Byte store by low address
  logic [7:0] last = 8'h00; // Last byte put on the data lines
  logic [3:0] cnt = 4'h0; // Wait cycles still to hold
  ////////////////////////////////////////////////////////////////////////////
  // Address latch, byte store and wait count
  always_ff @(posedge clk_i)
  begin
    if (als_i)
    begin
      lat_o <= {upper_i & upper_oe_i, ad_i};
    end
    if (!wr_n_i)
    begin
      mem[lat_o[7:0]] <= ad_i;
      wdat_o <= ad_i;
    end
    if (!rd_n_i)
    begin
      last <= mem[lat_o[7:0]];
    end
    cnt <= als_i ? hold_i : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);
  end
  // Data only under the read strobe, inverted leftovers otherwise
  assign ad_o = !rd_n_i ? mem[lat_o[7:0]] : ~last;
  // Wait low from latch strobe until the count runs out
  assign wait_n_o = !(als_i || cnt != 4'h0);
endmodule : ebw_ext_mem
`default_nettype wire

// file: ebw_tb.sv
// Self-checking bench for the external bus wait controller.
// Assumes the package, controller, checker and memory model are compiled.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst, req_v, busy, ack, intl, reg_wr, reg_rd, als, rd_n, wr_n;
  logic ad_oe, wait_n, spin, wpin, got_int;
  ebw_pkg::ebw_req_s req;
  logic [7:0] rdata, ad_out, ad_in, wdat;
  logic [1:0] reg_a;
  logic [15:0] reg_wd, reg_q;
  logic [11:0] up, up_oe;
  logic [19:0] lat;
  logic [3:0] hold;
  int n_errors, comparisons, lat_c, na, ns, base;
  ebw_bus_ctrl u_ebw_bus_ctrl (.CLK_I(clk), .RESET_I(rst), .REQ_VALID_I(req_v),
    .REQ_I(req), .BUSY_O(busy), .ACK_O(ack), .RDATA_O(rdata), .INTERNAL_O(intl),
    .REG_ADDR_I(reg_a), .REG_WDATA_I(reg_wd), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
    .REG_RDATA_O(reg_q), .ADDRESS_LATCH_STROBE_O(als), .RD_N_O(rd_n), .WR_N_O(wr_n),
    .MUXED_ADDR_DATA_O(ad_out), .MUXED_ADDR_DATA_OE_O(ad_oe), .MUXED_ADDR_DATA_I(ad_in),
    .UPPER_ADDR_O(up), .UPPER_ADDR_OE_O(up_oe), .WAIT_N_I(wait_n),
    .STROBE_PINS_EN_O(spin), .WAIT_PIN_EN_O(wpin));
  ebw_ext_mem u_ebw_ext_mem (.clk_i(clk), .als_i(als), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .ad_i(ad_out), .upper_i(up), .upper_oe_i(up_oe), .hold_i(hold), .ad_o(ad_in),
    .wait_n_o(wait_n), .lat_o(lat), .wdat_o(wdat));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and compares
  task automatic conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp)
    begin
      n_errors++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_cnt
  ////////////////////////////////////////////////////////////////////////////
  // Register port cycles
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_a <= a;
    reg_wd <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_a <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(20'(reg_q), 20'(exp));
  endtask : rd
  // One request; counts latency, latch and strobe cycles
  task automatic go(input logic [19:0] a, input logic w, input logic [7:0] d);
    int i;
    lat_c = 0;
    na = 0;
    ns = 0;
    @(posedge clk);
    req_v <= 1'b1;
    req <= '{a, w, d};
    for (i = 0; i < 60; i++)
    begin
      @(posedge clk);
      req_v <= 1'b0;
      #1;
      lat_c++;
      na += int'(als);
      ns += int'(!(rd_n && wr_n));
      got_int = intl;
      if (ack === 1'b1)
        break;
    end
    if (i == 60)
    begin
      n_errors++;
      conclude();
    end
  endtask : go
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs;
    rd(ebw_pkg::OFS_MODE, 16'h0020);
    rd(ebw_pkg::OFS_WAIT_LOW, 16'h00AA);
    rd(ebw_pkg::OFS_WAIT_HIGH, 16'hAAAA);
    wr(ebw_pkg::OFS_STATUS, 16'h00FF);
    rd(ebw_pkg::OFS_STATUS, 16'h0001);
    wr(ebw_pkg::OFS_WAIT_HIGH, 16'hAA55);
    rd(ebw_pkg::OFS_WAIT_HIGH, 16'hAA55);
    chk(20'({spin, wpin}), 20'h0);
  endtask : t_regs
  task automatic t_timing;
    int aw;
    int n;
    for (aw = 0; aw < 2; aw++)
      for (n = 0; n < 3; n++)
      begin
        wr(ebw_pkg::OFS_MODE, 16'(aw * 32 + 7));
        wr(ebw_pkg::OFS_WAIT_HIGH, {8'hAA, {4{2'(n)}}});
        go(20'h4A123, 1'b1, 8'(n + 16));
        if (aw + n == 0)
          base = lat_c;
        chk_cnt(na, 1 + aw);
        chk_cnt(ns, 1 + n);
        chk_cnt(lat_c, base + aw + n);
        chk(20'(wdat), 20'(n + 16));
        chk(20'({spin, up_oe}), 20'h1FFF);
      end
    chk(lat, 20'h4A123);
  endtask : t_timing
  task automatic t_mask;
    wr(ebw_pkg::OFS_MODE, 16'h0021);
    go(20'h54321, 1'b1, 8'h3C);
    chk(lat, 20'h00021);
    chk(20'(up_oe), 20'h0);
  endtask : t_mask
  task automatic t_read;
    wr(ebw_pkg::OFS_MODE, 16'h0027);
    wr(ebw_pkg::OFS_WAIT_HIGH, 16'hAAAA);
    go(20'h4A177, 1'b1, 8'h5C);
    go(20'h4A177, 1'b0, 8'h00);
    chk(20'(rdata), 20'h5C);
  endtask : t_read
  task automatic t_internal;
    logic [19:0] ad [5];
    logic [7:0] md [5];
    int k;
    ad = '{20'h0F000, 20'h0FFE0, 20'h00100, 20'h00100, 20'h0FFD5};
    md = '{8'h27, 8'h27, 8'h67, 8'h27, 8'h27};
    for (k = 0; k < 5; k++)
    begin
      wr(ebw_pkg::OFS_MODE, 16'(md[k]));
      go(ad[k], 1'b0, 8'h00);
      chk_cnt(lat_c, k < 3 ? 1 : base + 3);
      chk(20'(got_int), 20'(k < 4));
      chk_cnt(na, k < 4 ? 0 : 2);
    end
  endtask : t_internal
  task automatic t_ext_wait;
    wr(ebw_pkg::OFS_WAIT_HIGH, 16'hAAAE);
    hold <= 4'h6;
    go(20'h4A123, 1'b1, 8'h11);
    chk(20'(wpin), 20'h1);
    chk_cnt(int'(ns >= 6 && ns <= 11), 1);
    hold <= 4'h0;
    wr(ebw_pkg::OFS_WAIT_HIGH, 16'hAAAA);
    rd(ebw_pkg::OFS_WAIT_HIGH, 16'hAAAA);
    chk(20'(wpin), 20'h0);
  endtask : t_ext_wait
  ////////////////////////////////////////////////////////////////////////////
  // Clock and main sequence
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    rst = 1'b1;
    req_v = 1'b0;
    req = '0;
    reg_a = 2'h0;
    reg_wd = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    hold = 4'h0;
    n_errors = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_timing();
    t_mask();
    t_read();
    t_internal();
    t_ext_wait();
    conclude();
  end
endmodule : testbench
`default_nettype wire
